// ==== design/idm_decode.sv ====
`timescale 1ns/1ps
// Contract
// - Lower 128 bytes at 00H-7FH, direct and indirect.
// - Upper 128 bytes at 80H-FFH, indirect only.
// - Special function space at 80H-FFH, direct only.
// - Above 7FH: direct goes to SPECIAL_FUNCTION_SPACE, indirect to upper RAM.
// - Upper RAM and SPECIAL_FUNCTION_SPACE storage are physically separate.
// - Expanded RAM of 256 or 768 bytes, separate storage.
// - Expanded RAM is bottom of external data space.
// - Select clear: moves in range served on-chip, either pointer.
// - Expanded RAM access leaves port 0 and strobes idle.
// - Port 2 keeps latch contents during 8-bit pointer external addressing.
// - Select clear, above range: standard bus cycle on ports.
// - Select set, 8-bit pointer: address muxed with data on port 0.
// - Select set, data pointer: high on port 2, low on port 0.
// - Select set: write strobe bit 6, read strobe bit 7, low.
// - Stack uses 256 internal bytes, never expanded RAM.
module idm_decode #(
  parameter int ONCHIP_EXPANDED_STORE_BYTES = idm_pkg::ONCHIP_EXPANDED_STORE_SMALL
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire idm_pkg::idm_int_req_s intReq,
  input  wire idm_pkg::idm_ext_req_s extReq,
  input  wire logic                 disableWrite,
  input  wire logic                 disableValue,
  input  wire logic [7:0]           port2Latch,
  input  wire logic [7:0]           sfrRdata,
  input  wire logic [7:0]           port0In,
  output logic                      sfrWrite,
  output logic                      sfrRead,
  output logic [7:0]                sfrAddr,
  output logic [7:0]                sfrWdata,
  output logic [7:0]                intRdata,
  output logic                      intDone,
  output logic [7:0]                extRdata,
  output logic                      extDone,
  output logic                      extBusy,
  output logic                      expanded_ram_disable,
  output logic [7:0]                port0Out,
  output logic                      port0Oe_n,
  output logic [7:0]                port2Out,
  output logic                      ale,
  output logic                      wrStrobe_n,
  output logic                      rdStrobe_n
);
  localparam int EAW = $clog2(ONCHIP_EXPANDED_STORE_BYTES);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ADDR  = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_END   = 4'b1000
  } idm_bus_e;

  idm_bus_e    state;
  logic [1:0]  phaseCnt;
  logic        busWrite;
  logic [7:0]  busLow;
  logic [7:0]  busData;

  function automatic logic isUpper(input logic [7:0] a);
    return a > idm_pkg::LOWER_TOP;
  endfunction

  // Route decode, internal space
  logic toSfr, toLower, toUpper;
  always_comb begin
    toSfr   = intReq.valid && intReq.mode == idm_pkg::IDM_DIRECT
              && isUpper(intReq.addr);
    toLower = intReq.valid && !isUpper(intReq.addr);
    toUpper = intReq.valid && intReq.mode != idm_pkg::IDM_DIRECT
              && isUpper(intReq.addr);
  end

  logic [7:0] lowerQ, upperQ, eramQ;
  logic       useLowerQ, useUpperQ;
  idm_ram #(.DEPTH(128), .AW(7)) uLower (
    .clock (clock),
    .we    (toLower && intReq.write),
    .addr  (intReq.addr[6:0]),
    .wdata (intReq.wdata),
    .rdata (lowerQ)
  );
  idm_ram #(.DEPTH(128), .AW(7)) uUpper (
    .clock (clock),
    .we    (toUpper && intReq.write),
    .addr  (intReq.addr[6:0]),
    .wdata (intReq.wdata),
    .rdata (upperQ)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      sfrWrite <= 1'b0;
      sfrRead  <= 1'b0;
      sfrAddr  <= 8'h00;
      sfrWdata <= 8'h00;
    end else begin
      sfrWrite <= toSfr && intReq.write;
      sfrRead  <= toSfr && !intReq.write;
      sfrAddr  <= intReq.addr;
      sfrWdata <= intReq.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      useLowerQ <= 1'b0;
      useUpperQ <= 1'b0;
      intDone   <= 1'b0;
    end else begin
      useLowerQ <= toLower;
      useUpperQ <= toUpper;
      intDone   <= intReq.valid;
    end
  end
  // SPECIAL_FUNCTION_SPACE data returns with the same one-cycle latency as RAM
  assign intRdata = useLowerQ ? lowerQ : (useUpperQ ? upperQ : sfrRdata);

  always_ff @(posedge clock) begin
    if (rst) begin
      expanded_ram_disable <= 1'b0;
    end else if (disableWrite) begin
      expanded_ram_disable <= disableValue;
    end
  end

  // External-data move steering
  logic [15:0] extAddr;
  logic        hitEram, startBus;
  always_comb begin
    extAddr = extReq.useDptr ? extReq.data_pointer_16 : {8'h00, extReq.ptr8};
    hitEram = !expanded_ram_disable && extAddr < 16'(ONCHIP_EXPANDED_STORE_BYTES);
    startBus = extReq.valid && !hitEram && state == ST_IDLE;
  end

  idm_ram #(.DEPTH(ONCHIP_EXPANDED_STORE_BYTES), .AW(EAW)) uEram (
    .clock (clock),
    .we    (extReq.valid && hitEram && extReq.write),
    .addr  (extAddr[EAW-1:0]),
    .wdata (extReq.wdata),
    .rdata (eramQ)
  );

  logic eramAck;
  always_ff @(posedge clock) begin
    if (rst) begin
      eramAck <= 1'b0;
    end else begin
      eramAck <= extReq.valid && hitEram && state == ST_IDLE;
    end
  end
  // Registered so data and done leave on the same edge
  always_ff @(posedge clock) begin
    if (rst) begin
      extRdata <= 8'h00;
    end else if (eramAck) begin
      extRdata <= eramQ;
    end else if (state == ST_END) begin
      extRdata <= busData;
    end
  end

  // External bus cycle sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state    <= ST_IDLE;
      phaseCnt <= 2'h0;
      busWrite <= 1'b0;
      busLow   <= 8'h00;
      busData  <= 8'h00;
      extDone  <= 1'b0;
    end else begin
      extDone <= eramAck;
      unique case (state)
        ST_IDLE: begin
          if (startBus) begin
            state    <= ST_ADDR;
            busWrite <= extReq.write;
            busLow   <= extAddr[7:0];
            busData  <= extReq.wdata;
          end
        end
        ST_ADDR: begin
          state    <= ST_DATA;
          phaseCnt <= 2'h0;
        end
        ST_DATA: begin
          phaseCnt <= phaseCnt + 2'h1;
          if (phaseCnt == idm_pkg::BUS_PHASES) begin
            state <= ST_END;
            if (!busWrite) begin
              busData <= port0In;
            end
          end
        end
        ST_END: begin
          state   <= ST_IDLE;
          extDone <= 1'b1;
        end
      endcase
    end
  end

  // Pin drive
  logic [7:0] port2Hi;
  always_ff @(posedge clock) begin
    if (rst) begin
      port2Hi <= 8'h00;
    end else if (startBus) begin
      port2Hi <= extReq.data_pointer_16[15:8];
    end
  end

  logic port2Addr;
  always_ff @(posedge clock) begin
    if (rst) begin
      port2Addr <= 1'b0;
    end else if (startBus) begin
      port2Addr <= extReq.useDptr;
    end else if (state == ST_END) begin
      port2Addr <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      port0Out   <= idm_pkg::PORT_IDLE;
      port0Oe_n  <= 1'b1;
      port2Out   <= idm_pkg::PORT_IDLE;
      ale        <= 1'b0;
      wrStrobe_n <= 1'b1;
      rdStrobe_n <= 1'b1;
      extBusy    <= 1'b0;
    end else begin
      extBusy <= state != ST_IDLE || startBus;
      port2Out <= (port2Addr && state != ST_IDLE) ? port2Hi : port2Latch;
      ale        <= state == ST_ADDR;
      wrStrobe_n <= !(state == ST_DATA && busWrite);
      rdStrobe_n <= !(state == ST_DATA && !busWrite);
      if (state == ST_ADDR) begin
        port0Out  <= busLow;
        port0Oe_n <= 1'b0;
      end else if (state == ST_DATA && busWrite) begin
        port0Out  <= busData;
        port0Oe_n <= 1'b0;
      end else begin
        port0Out  <= idm_pkg::PORT_IDLE;
        port0Oe_n <= 1'b1;
      end
    end
  end

  // Assertions
  property p_onchip_expanded_store_quiet;
    @(posedge clock) disable iff (rst)
      (extReq.valid && hitEram && state == ST_IDLE) |=> ##1
      (port0Oe_n && wrStrobe_n && rdStrobe_n);
  endproperty
  a_onchip_expanded_store_quiet: assert property (p_onchip_expanded_store_quiet)
    else $error("expanded RAM access disturbed port pins");

  property p_sfr_direct;
    @(posedge clock) disable iff (rst)
      sfrWrite |-> $past(intReq.mode) == idm_pkg::IDM_DIRECT;
  endproperty
  a_sfr_direct: assert property (p_sfr_direct)
    else $error("SPECIAL_FUNCTION_SPACE write from non-direct mode");

  property p_route;
    @(posedge clock) disable iff (rst)
      (intReq.valid && intReq.mode == idm_pkg::IDM_INDIRECT
       && isUpper(intReq.addr)) |=> !sfrWrite && !sfrRead && useUpperQ;
  endproperty
  a_route: assert property (p_route)
    else $error("indirect high access reached SPECIAL_FUNCTION_SPACE");

  property p_reset_sel;
    @(posedge clock) rst |=> !expanded_ram_disable;
  endproperty
  a_reset_sel: assert property (p_reset_sel)
    else $error("select bit not cleared by reset");

  sequence s_addr_phase;
    ale && !port0Oe_n;
  endsequence
  sequence s_strobe;
    (!wrStrobe_n || !rdStrobe_n) [*4];
  endsequence
  property p_bus_cycle;
    @(posedge clock) disable iff (rst)
      startBus |=> ##1 s_addr_phase ##1 s_strobe;
  endproperty
  a_bus_cycle: assert property (p_bus_cycle)
    else $error("external bus cycle malformed");

  property p_write_strobe;
    @(posedge clock) disable iff (rst)
      (startBus && extReq.write) |=> ##2 (!wrStrobe_n && rdStrobe_n);
  endproperty
  a_write_strobe: assert property (p_write_strobe)
    else $error("write strobe wrong");

  property p_port2_hi;
    @(posedge clock) disable iff (rst)
      (startBus && extReq.useDptr) |=> ##1 port2Out == port2Hi;
  endproperty
  a_port2_hi: assert property (p_port2_hi)
    else $error("port 2 lacks high address");

  property p_port2_latch;
    @(posedge clock) disable iff (rst)
      (state == ST_IDLE && !port2Addr) |=> port2Out == $past(port2Latch);
  endproperty
  a_port2_latch: assert property (p_port2_latch)
    else $error("port 2 latch not driven");
endmodule

// ==== design/idm_pkg.sv ====
package idm_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          XADDR_W       = 16;
  localparam logic [7:0]  LOWER_TOP     = 8'h7F;
  localparam logic [7:0]  PORT_IDLE     = 8'hFF;
  localparam int          ONCHIP_EXPANDED_STORE_SMALL    = 256;
  localparam int          ONCHIP_EXPANDED_STORE_LARGE    = 768;
  localparam logic [1:0]  BUS_PHASES    = 2'h3;

  typedef enum logic [1:0] {
    IDM_DIRECT   = 2'h0,
    IDM_INDIRECT = 2'h1,
    IDM_STACK    = 2'h2
  } idm_mode_e;

  // Core request for internal data space
  typedef struct packed {
    logic            valid;
    logic            write;
    idm_mode_e       mode;
    logic [7:0]      addr;
    logic [7:0]      wdata;
  } idm_int_req_s;

  // Core request for external-data move
  typedef struct packed {
    logic            valid;
    logic            write;
    logic            useDptr;
    logic [7:0]      ptr8;
    logic [15:0]     data_pointer_16;
    logic [7:0]      wdata;
  } idm_ext_req_s;
endpackage

// ==== design/idm_ram.sv ====
`timescale 1ns/1ps
module idm_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clock,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ==== dv/idm_xmem_model.sv ====
`timescale 1ns/1ps
module idm_xmem_model #(
  parameter int LAG = 0
) (
  input  wire logic       clock,
  input  wire logic [7:0] port0Out,
  input  wire logic [7:0] port2Out,
  input  wire logic       ale,
  input  wire logic       wrStrobe_n,
  input  wire logic       rdStrobe_n,
  output logic      [7:0] port0In
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr   = 16'h0000;
  logic [7:0]  last   = 8'h00;
  int          lowCnt = 0;

  always @(posedge clock) begin
    if (ale)
      addr <= {port2Out, port0Out};
    if (!wrStrobe_n)
      mem[addr] <= port0Out;
    lowCnt <= rdStrobe_n ? 0 : lowCnt + 1;
    last <= port0In;
  end

  // Released bus toggles so stale data never looks valid
  assign port0In = (!rdStrobe_n && lowCnt >= LAG) ? mem[addr] : ~last;
endmodule

// ==== dv/internal_data_memory_decode_tb_top.sv ====
`timescale 1ns/1ps
module internal_data_memory_decode_tb_top;
  localparam int STROBE_CYC = int'(idm_pkg::BUS_PHASES) + 1;
  logic                  clock        = 0;
  logic                  rst          = 1;
  idm_pkg::idm_int_req_s intReq       = '0;
  idm_pkg::idm_ext_req_s extReq       = '0;
  logic                  disableWrite = 0;
  logic                  disableValue = 0;
  logic [7:0]            port2Latch   = 8'h5A;
  logic [7:0]            lfsr         = 8'h46;
  logic [7:0]            sfrRdata, port0In, sfrAddr, sfrWdata, intRdata;
  logic [7:0]            extRdata, port0Out, port2Out;
  logic                  sfrWrite, sfrRead, intDone, extDone, extBusy;
  logic                  expanded_ram_disable, port0Oe_n, ale;
  logic                  wrStrobe_n, rdStrobe_n, sawWr, sawRd;
  logic [15:0]           sfrSeen, busAddr, busAct, busMark, lowRun, lowLen;
  logic [8:0]            note;
  logic [8:0]            notes [$];
  int                    miscompares  = 0;
  int                    numChecks    = 0;

  initial forever #10 clock = ~clock;
  assign sfrRdata = ~sfrAddr;

  idm_decode #(.ONCHIP_EXPANDED_STORE_BYTES(idm_pkg::ONCHIP_EXPANDED_STORE_SMALL)) i_idm_decode (
    .clock(clock), .rst(rst), .intReq(intReq), .extReq(extReq),
    .disableWrite(disableWrite), .disableValue(disableValue),
    .port2Latch(port2Latch), .sfrRdata(sfrRdata), .port0In(port0In),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata), .intRdata(intRdata), .intDone(intDone),
    .extRdata(extRdata), .extDone(extDone), .extBusy(extBusy),
    .expanded_ram_disable(expanded_ram_disable), .port0Out(port0Out),
    .port0Oe_n(port0Oe_n), .port2Out(port2Out), .ale(ale),
    .wrStrobe_n(wrStrobe_n), .rdStrobe_n(rdStrobe_n));

  idm_xmem_model #(.LAG(2)) i_idm_xmem_model (
    .clock(clock), .port0Out(port0Out), .port2Out(port2Out), .ale(ale),
    .wrStrobe_n(wrStrobe_n), .rdStrobe_n(rdStrobe_n), .port0In(port0In));

  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic tallyAndFinish;
    $display("checks %0d, mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic tick;
    @(posedge clock);
    #1;
  endtask

  // Writes note an unchecked entry so every done pulse pops one
  task automatic int_op(input logic wr, input logic [1:0] md,
                        input logic [7:0] a, input logic [7:0] d,
                        input logic chk);
    notes.push_back({chk, d});
    tick;
    intReq.valid = 1;
    intReq.write = wr;
    intReq.mode = idm_pkg::idm_mode_e'(md);
    intReq.addr = a;
    intReq.wdata = d;
    tick;
    intReq.valid = 0;
    tick;
  endtask

  // Valid must drop after the take edge or a repeat cycle starts
  task automatic ext_op(input logic wr, input logic useD,
                        input logic [15:0] a, input logic [7:0] d,
                        input logic chk);
    int n = 0;
    notes.push_back({chk, d});
    tick;
    extReq.valid = 1;
    extReq.write = wr;
    extReq.useDptr = useD;
    extReq.ptr8 = a[7:0];
    extReq.data_pointer_16 = a;
    extReq.wdata = wr ? d : lfsr;
    lfsr = lfsrNext(lfsr);
    tick;
    extReq.valid = 0;
    while (extDone !== 1'h1 && n < 40) begin
      tick;
      n++;
    end
    if (n >= 40)
      check("extDone", 16'h0000, 16'h0001);
    tick;
  endtask

  task automatic set_sel(input logic v);
    tick;
    disableWrite = 1;
    disableValue = v;
    tick;
    disableWrite = 0;
    check("select", {15'h0, expanded_ram_disable}, {15'h0, v});
  endtask

  always @(posedge clock) begin
    if (sfrWrite)
      sfrSeen <= {sfrAddr, sfrWdata};
    if (ale) begin
      check("busy", {15'h0, extBusy}, 16'h0001);
      busAddr <= {port2Out, port0Out};
      sawWr <= 0;
      sawRd <= 0;
    end
    if (!wrStrobe_n)
      sawWr <= 1;
    if (!rdStrobe_n)
      sawRd <= 1;
    if (ale || !wrStrobe_n || !rdStrobe_n || !port0Oe_n)
      busAct <= busAct + 16'h0001;
    lowRun <= (!wrStrobe_n || !rdStrobe_n) ? lowRun + 16'h0001 : 16'h0000;
    if (lowRun != 0 && wrStrobe_n && rdStrobe_n)
      lowLen <= lowRun;
    if ((intDone === 1'h1 || extDone === 1'h1) && notes.size() > 0) begin
      note = notes.pop_front();
      if (note[8])
        check("rdata", {8'h00, intDone ? intRdata : extRdata},
              {8'h00, note[7:0]});
    end
  end

  initial begin
    logic [6:0] lo;
    busAct = 16'h0000;
    lowRun = 16'h0000;
    repeat (2) @(posedge clock);
    #1;
    rst = 0;
    check("idle", {wrStrobe_n, rdStrobe_n, port0Oe_n, ale,
          expanded_ram_disable, 3'h0, port0Out}, 16'hE0FF);
    check("port2", {8'h00, port2Out}, 16'h00FF);
    int_op(1, 2'h0, 8'h7F, 8'hA5, 0);
    int_op(0, 2'h1, 8'h7F, 8'hA5, 1);
    int_op(1, 2'h1, 8'h90, 8'h11, 0);
    int_op(1, 2'h0, 8'h90, 8'h3C, 0);
    check("sfr", sfrSeen, 16'h903C);
    int_op(0, 2'h1, 8'h90, 8'h11, 1);
    int_op(0, 2'h0, 8'h90, 8'h6F, 1);
    int_op(1, 2'h2, 8'hFF, 8'hC3, 0);
    int_op(0, 2'h1, 8'hFF, 8'hC3, 1);
    for (int i = 0; i < 6; i++) begin
      lo = lfsr[6:0];
      lfsr = lfsrNext(lfsr);
      int_op(1, 2'h1, {1'h0, lo}, lfsr, 0);
      int_op(0, 2'h0, {1'h0, lo}, lfsr, 1);
      lfsr = lfsrNext(lfsr);
    end
    busMark = busAct;
    ext_op(1, 0, 16'h00A0, 8'h77, 0);
    ext_op(0, 1, 16'h00A0, 8'h77, 1);
    ext_op(1, 1, 16'h00FF, 8'h88, 0);
    ext_op(0, 0, 16'h00FF, 8'h88, 1);
    check("busAct", busAct, busMark);
    ext_op(1, 1, 16'h0100, 8'h99, 0);
    check("addr", busAddr, 16'h0100);
    check("wrOnly", {14'h0, sawWr, sawRd}, 16'h0002);
    ext_op(0, 1, 16'h0100, 8'h99, 1);
    check("strobe", lowLen, 16'(STROBE_CYC));
    set_sel(1);
    ext_op(1, 0, 16'h0042, 8'hE1, 0);
    check("addr", busAddr, {port2Latch, 8'h42});
    ext_op(0, 0, 16'h0042, 8'hE1, 1);
    check("rdOnly", {14'h0, sawWr, sawRd}, 16'h0001);
    ext_op(1, 1, 16'h00A0, 8'h3E, 0);
    check("addr", busAddr, 16'h00A0);
    check("strobe", lowLen, 16'(STROBE_CYC));
    ext_op(0, 1, {port2Latch, 8'h42}, 8'hE1, 1);
    set_sel(0);
    ext_op(0, 0, 16'h00A0, 8'h77, 1);
    tallyAndFinish;
  end

  initial begin
    #100000;
    miscompares++;
    tallyAndFinish;
  end
endmodule
